// [core/aer_corr_regs.sv]
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module aer_corr_regs (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hot_rst_n,
  input wire aer_pkg::axil_req_t axil_req,
  output aer_pkg::axil_rsp_t axil_rsp,
  input wire aer_pkg::corr_event_t corr_event,
  input wire aer_pkg::uncorr_event_t uncorr_event,
  input wire aer_pkg::uncorr_event_t uncorrectable_error_mask,
  output logic report_correctable,
  output logic report_nonfatal,
  output logic report_fatal
);

  aer_pkg::main_state_t s_q;
  aer_pkg::main_state_t s_d;

  logic bus_rst_n;
  logic wr_en;
  logic [31:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_hit;
  logic [31:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_hit;
  logic [31:0] byte_mask;
  logic [31:0] status_clr;
  logic [31:0] status_vec;
  logic [31:0] event_vec;
  logic [aer_pkg::CORR_COUNT-1:0] event_bits;
  logic [aer_pkg::CORR_COUNT-1:0] flag_bits;
  logic sb_en;
  logic db_en;

  // The bus front end restarts on any reset; the sticky bank only on power-on.
  assign bus_rst_n = rst_n & hot_rst_n;

  axil_reg_slave u_slave (
    .clk(clk),
    .rst_n(bus_rst_n),
    .req(axil_req),
    .rsp(axil_rsp),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_hit(wr_hit),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_hit(rd_hit)
  );

  // Memory error reporting enables as currently held.
  assign sb_en = s_q.memctl[aer_pkg::SB_EN_POS];
  assign db_en = s_q.memctl[aer_pkg::DB_EN_POS];
  assign event_bits = corr_event;

  // Byte enables widened to a bit mask.
  always_comb
  begin
    for (int b = 0; b < 4; b++)
    begin
      byte_mask[b*8 +: 8] = {8{wr_strb[b]}};
    end
  end

  // Write-one-to-clear strobes for the status flags.
  assign status_clr = (wr_en && wr_addr == aer_pkg::STATUS_OFFSET) ?
    (wr_data & byte_mask) : 32'h00000000;

  // One sticky flag per correctable event; the single-bit flag is held at zero while
  // its reporting enable is clear.
  generate
    for (genvar i = 0; i < aer_pkg::CORR_COUNT; i++)
    begin : g_flag
      sticky_flag_cell #(
        .RESET_VALUE(aer_pkg::STATUS_RESET[aer_pkg::CORR_POS[i]])
      ) u_flag (
        .clk(clk),
        .rst_n(rst_n),
        .keep_en((i == aer_pkg::SINGLE_BIT_INDEX) ? sb_en : 1'b1),
        .set(event_bits[i]),
        .clr(status_clr[aer_pkg::CORR_POS[i]]),
        .flag_q(flag_bits[i])
      );
    end
  endgenerate

  // Flags and events spread onto their register positions; other bits stay zero.
  always_comb
  begin
    status_vec = 32'h00000000;
    event_vec = 32'h00000000;
    for (int k = 0; k < aer_pkg::CORR_COUNT; k++)
    begin
      status_vec[aer_pkg::CORR_POS[k]] = flag_bits[k];
      event_vec[aer_pkg::CORR_POS[k]] = event_bits[k];
    end
    status_vec[aer_pkg::SINGLE_BIT_POS] = flag_bits[aer_pkg::SINGLE_BIT_INDEX] & sb_en;
    event_vec[aer_pkg::SINGLE_BIT_POS] = event_bits[aer_pkg::SINGLE_BIT_INDEX] & sb_en;
  end

  // Register writes, reserved-bit gating and error reporting.
  always_comb
  begin
    logic [31:0] rpt_cor_vec;
    logic [3:0] unc_live;
    logic [3:0] unc_sev;
    rpt_cor_vec = 32'h00000000;
    unc_live = 4'h0;
    unc_sev = 4'h0;
    s_d = s_q;
    if (wr_en && wr_addr == aer_pkg::MEMCTL_OFFSET)
    begin
      s_d.memctl = ((s_q.memctl & ~byte_mask) | (wr_data & byte_mask)) &
        aer_pkg::MEMCTL_BITS;
    end
    if (wr_en && wr_addr == aer_pkg::MASK_OFFSET)
    begin
      s_d.mask = ((s_q.mask & ~byte_mask) | (wr_data & byte_mask)) &
        aer_pkg::CORR_BITS;
    end
    if (wr_en && wr_addr == aer_pkg::SEVERITY_OFFSET)
    begin
      s_d.severity = ((s_q.severity & ~byte_mask) | (wr_data & byte_mask)) &
        aer_pkg::SEV_BITS;
    end
    // Enable-dependent bits are forced to zero and so refuse writes.
    if (!s_d.memctl[aer_pkg::SB_EN_POS])
      s_d.mask[aer_pkg::SINGLE_BIT_POS] = 1'b0;
    if (!s_d.memctl[aer_pkg::DB_EN_POS])
      s_d.severity[aer_pkg::DOUBLE_BIT_POS] = 1'b0;
    // An event is reported unless its mask bit is set or, for the single-bit and double-bit errors, its enable is clear.
    rpt_cor_vec = event_vec & ~s_q.mask;
    s_d.rpt_cor = |rpt_cor_vec;
    unc_live = uncorr_event & ~uncorrectable_error_mask;
    unc_live[3] = unc_live[3] & db_en;
    unc_sev = {s_q.severity[aer_pkg::DOUBLE_BIT_POS], s_q.severity[aer_pkg::ACCESS_POS],
      s_q.severity[aer_pkg::UR_POS], s_q.severity[aer_pkg::ECRC_POS]};
    s_d.rpt_fat = |(unc_live & unc_sev);
    s_d.rpt_nf = |(unc_live & ~unc_sev);
    // A warm reset drops pending report pulses but keeps every sticky bit.
    if (!hot_rst_n)
    begin
      s_d.rpt_cor = 1'b0;
      s_d.rpt_nf = 1'b0;
      s_d.rpt_fat = 1'b0;
    end
  end

  // Write address decode.
  always_comb
  begin
    wr_hit = (wr_addr == aer_pkg::SEVERITY_OFFSET) || (wr_addr == aer_pkg::STATUS_OFFSET) ||
      (wr_addr == aer_pkg::MASK_OFFSET) || (wr_addr == aer_pkg::MEMCTL_OFFSET);
  end

  // Read multiplexer; unmapped addresses read zero with an error answer.
  always_comb
  begin
    rd_hit = 1'b1;
    rd_data = 32'h00000000;
    unique case (rd_addr)
      aer_pkg::SEVERITY_OFFSET: rd_data = s_q.severity;
      aer_pkg::STATUS_OFFSET: rd_data = status_vec;
      aer_pkg::MASK_OFFSET: rd_data = s_q.mask;
      aer_pkg::MEMCTL_OFFSET: rd_data = s_q.memctl;
      default: rd_hit = 1'b0;
    endcase
  end

  // Sticky bank register, loaded with MAIN_RESET only by the power-on reset.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      s_q <= aer_pkg::MAIN_RESET;
    else
      s_q <= s_d;
  end

  // Report pulses toward the upstream message logic.
  assign report_correctable = s_q.rpt_cor;
  assign report_nonfatal = s_q.rpt_nf;
  assign report_fatal = s_q.rpt_fat;

endmodule : aer_corr_regs

`default_nettype wire

// [core/aer_pkg.sv]
package aer_pkg;

  // Register byte addresses.
  localparam logic [31:0] SEVERITY_OFFSET = 32'h0000010C;
  localparam logic [31:0] STATUS_OFFSET = 32'h00000110;
  localparam logic [31:0] MASK_OFFSET = 32'h00000114;
  localparam logic [31:0] MEMCTL_OFFSET = 32'h00000130;

  // Severity field positions.
  localparam int ECRC_POS = 19;
  localparam int UR_POS = 20;
  localparam int ACCESS_POS = 21;
  localparam int DOUBLE_BIT_POS = 31;

  // Correctable status and mask field positions.
  localparam int RCV_POS = 0;
  localparam int BAD_PACKET_POS = 6;
  localparam int BADLINK_POS = 7;
  localparam int ROLLOVER_POS = 8;
  localparam int TIMEOUT_POS = 12;
  localparam int ADVISORY_POS = 13;
  localparam int SINGLE_BIT_POS = 31;
  localparam int CORR_COUNT = 7;
  localparam int SINGLE_BIT_INDEX = 6;
  localparam int CORR_POS [CORR_COUNT] = '{RCV_POS, BAD_PACKET_POS, BADLINK_POS,
    ROLLOVER_POS, TIMEOUT_POS, ADVISORY_POS, SINGLE_BIT_POS};

  // Memory error control field positions.
  localparam int SB_EN_POS = 0;
  localparam int DB_EN_POS = 1;

  // Reset values and implemented bits.
  localparam logic [31:0] STATUS_RESET = 32'h00000000;
  localparam logic [31:0] MASK_RESET = 32'h00002000;
  localparam logic [31:0] SEVERITY_RESET = 32'h00000000;
  localparam logic [31:0] MEMCTL_RESET = 32'h00000000;
  localparam logic [31:0] CORR_BITS = 32'h800031C1;
  localparam logic [31:0] SEV_BITS = 32'h80380000;
  localparam logic [31:0] MEMCTL_BITS = 32'h00000003;

  // Bus responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic awvalid;
    logic [31:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [31:0] araddr;
    logic rready;
  } axil_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axil_rsp_t;

  typedef struct packed {
    logic single_bit_error_flag;
    logic advisory_nonfatal_flag;
    logic replay_timeout_flag;
    logic replay_rollover_flag;
    logic bad_link_packet_flag;
    logic bad_packet_flag;
    logic receiver_error_flag;
  } corr_event_t;

  typedef struct packed {
    logic double_bit_error;
    logic access_violation;
    logic unsupported_request;
    logic ecrc_error;
  } uncorr_event_t;

  typedef enum logic [2:0] {WR_WAIT = 3'h1, WR_EXEC = 3'h2, WR_RESP = 3'h4} wr_state_t;
  typedef enum logic [2:0] {RD_IDLE = 3'h1, RD_FETCH = 3'h2, RD_RESP = 3'h4} rd_state_t;

  typedef struct packed {
    wr_state_t wr_state;
    rd_state_t rd_state;
    logic aw_held;
    logic w_held;
    logic [31:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [31:0] araddr;
    axil_rsp_t rsp;
  } slave_state_t;

  typedef struct packed {
    logic flag;
  } flag_state_t;

  typedef struct packed {
    logic [31:0] mask;
    logic [31:0] severity;
    logic [31:0] memctl;
    logic rpt_cor;
    logic rpt_nf;
    logic rpt_fat;
  } main_state_t;

  localparam main_state_t MAIN_RESET = '{mask: MASK_RESET, severity: SEVERITY_RESET,
    memctl: MEMCTL_RESET, rpt_cor: 1'b0, rpt_nf: 1'b0, rpt_fat: 1'b0};

endpackage : aer_pkg

// [core/sticky_flag_cell.sv]
`timescale 1ns/1ps
`default_nettype none

module sticky_flag_cell #(
  parameter logic RESET_VALUE = 1'b0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic keep_en,
  input wire logic set,
  input wire logic clr,
  output logic flag_q
);

  aer_pkg::flag_state_t s_q;
  aer_pkg::flag_state_t s_d;

  // A set in the cycle of a clear wins; a cleared enable forces zero.
  always_comb
  begin
    s_d.flag = keep_en & (set | (s_q.flag & ~clr));
  end

  // The power-on reset clears the flag; the warm reset never reaches it.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      s_q.flag <= RESET_VALUE;
    else
      s_q <= s_d;
  end

  assign flag_q = s_q.flag;

endmodule : sticky_flag_cell

`default_nettype wire

// [core/axil_reg_slave.sv]
`timescale 1ns/1ps
`default_nettype none

module axil_reg_slave (
  input wire logic clk,
  input wire logic rst_n,
  input wire aer_pkg::axil_req_t req,
  output aer_pkg::axil_rsp_t rsp,
  output logic wr_en,
  output logic [31:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_hit,
  output logic [31:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_hit
);

  localparam aer_pkg::slave_state_t SLAVE_RESET = '{wr_state: aer_pkg::WR_WAIT,
    rd_state: aer_pkg::RD_IDLE, aw_held: 1'b0, w_held: 1'b0, awaddr: 32'h00000000,
    wdata: 32'h00000000, wstrb: 4'h0, araddr: 32'h00000000,
    rsp: '{awready: 1'b1, wready: 1'b1, bvalid: 1'b0, bresp: 2'h0, arready: 1'b1,
    rvalid: 1'b0, rdata: 32'h00000000, rresp: 2'h0}};

  aer_pkg::slave_state_t s_q;
  aer_pkg::slave_state_t s_d;

  // Address and data are taken in either order; the write runs once both are held.
  always_comb
  begin
    s_d = s_q;
    unique case (s_q.wr_state)
      aer_pkg::WR_WAIT:
      begin
        if (req.awvalid && s_q.rsp.awready)
        begin
          s_d.aw_held = 1'b1;
          s_d.awaddr = req.awaddr;
          s_d.rsp.awready = 1'b0;
        end
        if (req.wvalid && s_q.rsp.wready)
        begin
          s_d.w_held = 1'b1;
          s_d.wdata = req.wdata;
          s_d.wstrb = req.wstrb;
          s_d.rsp.wready = 1'b0;
        end
        if (s_d.aw_held && s_d.w_held)
          s_d.wr_state = aer_pkg::WR_EXEC;
      end
      aer_pkg::WR_EXEC:
      begin
        s_d.rsp.bvalid = 1'b1;
        s_d.rsp.bresp = wr_hit ? aer_pkg::RESP_OKAY : aer_pkg::RESP_SLVERR;
        s_d.wr_state = aer_pkg::WR_RESP;
      end
      aer_pkg::WR_RESP:
      begin
        if (req.bready)
        begin
          s_d.rsp.bvalid = 1'b0;
          s_d.aw_held = 1'b0;
          s_d.w_held = 1'b0;
          s_d.rsp.awready = 1'b1;
          s_d.rsp.wready = 1'b1;
          s_d.wr_state = aer_pkg::WR_WAIT;
        end
      end
      default: s_d.wr_state = aer_pkg::WR_WAIT;
    endcase
    unique case (s_q.rd_state)
      aer_pkg::RD_IDLE:
      begin
        if (req.arvalid)
        begin
          s_d.araddr = req.araddr;
          s_d.rsp.arready = 1'b0;
          s_d.rd_state = aer_pkg::RD_FETCH;
        end
      end
      aer_pkg::RD_FETCH:
      begin
        s_d.rsp.rvalid = 1'b1;
        s_d.rsp.rdata = rd_hit ? rd_data : 32'h00000000;
        s_d.rsp.rresp = rd_hit ? aer_pkg::RESP_OKAY : aer_pkg::RESP_SLVERR;
        s_d.rd_state = aer_pkg::RD_RESP;
      end
      aer_pkg::RD_RESP:
      begin
        if (req.rready)
        begin
          s_d.rsp.rvalid = 1'b0;
          s_d.rsp.arready = 1'b1;
          s_d.rd_state = aer_pkg::RD_IDLE;
        end
      end
      default: s_d.rd_state = aer_pkg::RD_IDLE;
    endcase
  end

  // Bus state register.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      s_q <= SLAVE_RESET;
    else
      s_q <= s_d;
  end

  // Outputs toward the bus and the register bank.
  assign rsp = s_q.rsp;
  assign wr_en = (s_q.wr_state == aer_pkg::WR_EXEC);
  assign wr_addr = s_q.awaddr;
  assign wr_data = s_q.wdata;
  assign wr_strb = s_q.wstrb;
  assign rd_addr = s_q.araddr;

endmodule : axil_reg_slave

`default_nettype wire

// [bench/aer_corr_regs_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module aer_corr_regs_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hot_rst_n,
  input wire aer_pkg::axil_req_t axil_req,
  input wire aer_pkg::axil_rsp_t axil_rsp,
  input wire aer_pkg::corr_event_t corr_event,
  input wire aer_pkg::uncorr_event_t uncorr_event,
  input wire aer_pkg::uncorr_event_t uncorrectable_error_mask,
  input wire logic report_correctable,
  input wire logic report_nonfatal,
  input wire logic report_fatal
);
  logic [31:0] ar_q;
  // Keeps the read address taken last, so read data can be judged by register.
  always_ff @(posedge clk)
  begin
    if (axil_req.arvalid && axil_rsp.arready)
      ar_q <= axil_req.araddr;
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n || !hot_rst_n);
  AST_COR_CAUSE: assert property (report_correctable |-> ($past(corr_event) != 7'h00))
    else $error("correctable report without event");
  AST_FAT_CAUSE: assert property (report_fatal |->
    (($past(uncorr_event) & ~$past(uncorrectable_error_mask)) != 4'h0))
    else $error("fatal without event");
  AST_NF_CAUSE: assert property (report_nonfatal |->
    (($past(uncorr_event) & ~$past(uncorrectable_error_mask)) != 4'h0))
    else $error("nonfatal without event");
  AST_WR_LAT: assert property (axil_req.awvalid && axil_rsp.awready && axil_req.wvalid
    && axil_rsp.wready |-> !axil_rsp.bvalid ##2 axil_rsp.bvalid) else $error("late write");
  AST_RD_LAT: assert property (axil_req.arvalid && axil_rsp.arready |-> ##2 axil_rsp.rvalid)
    else $error("late read");
  AST_R_HOLD: assert property (axil_rsp.rvalid |=>
    (axil_rsp.rvalid != $past(axil_req.rready)) && $stable(axil_rsp.rdata))
    else $error("read data not held until taken");
  AST_B_HOLD: assert property (axil_rsp.bvalid |=>
    (axil_rsp.bvalid != $past(axil_req.bready)) && $stable(axil_rsp.bresp))
    else $error("write response not held until taken");
  AST_RSVD: assert property (axil_rsp.rvalid && (ar_q == aer_pkg::STATUS_OFFSET
    || ar_q == aer_pkg::MASK_OFFSET) |-> (axil_rsp.rdata & ~aer_pkg::CORR_BITS) == 32'h0)
    else $error("reserved bits set");
endmodule : aer_corr_regs_chk
bind aer_corr_regs aer_corr_regs_chk chk_u (.clk(clk), .rst_n(rst_n), .hot_rst_n(hot_rst_n),
  .axil_req(axil_req), .axil_rsp(axil_rsp), .corr_event(corr_event),
  .uncorr_event(uncorr_event), .uncorrectable_error_mask(uncorrectable_error_mask),
  .report_correctable(report_correctable), .report_nonfatal(report_nonfatal),
  .report_fatal(report_fatal));
`default_nettype wire

// [bench/report_sink.sv]
`timescale 1ns/1ps
`default_nettype none
module report_sink (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic report_correctable,
  input wire logic report_nonfatal,
  input wire logic report_fatal,
  output int cor_cnt,
  output int unc_cnt
);
  // Tallies the messages that reach the root complex, one per cycle high.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cor_cnt <= 0;
      unc_cnt <= 0;
    end
    else
    begin
      cor_cnt <= cor_cnt + int'(report_correctable);
      unc_cnt <= unc_cnt + int'(report_nonfatal | report_fatal);
    end
  end
endmodule : report_sink
`default_nettype wire

// [bench/aer_corr_regs_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module aer_corr_regs_tb;
  logic clk;
  logic rst_n;
  logic hot_rst_n;
  aer_pkg::axil_req_t req;
  aer_pkg::axil_rsp_t rsp;
  aer_pkg::corr_event_t ce;
  aer_pkg::uncorr_event_t ue;
  aer_pkg::uncorr_event_t um;
  logic rc;
  logic rn;
  logic rf;
  int cor_cnt;
  int unc_cnt;
  int err_total;
  int num_checks;
  int exp_cor;
  int exp_unc;
  logic [31:0] seed;
  logic [31:0] x;
  logic [31:0] stat;
  logic [31:0] mask;
  logic [31:0] sev;
  logic [31:0] mem;

  aer_corr_regs dut_u (.clk(clk), .rst_n(rst_n), .hot_rst_n(hot_rst_n), .axil_req(req),
    .axil_rsp(rsp), .corr_event(ce), .uncorr_event(ue), .uncorrectable_error_mask(um),
    .report_correctable(rc), .report_nonfatal(rn), .report_fatal(rf));
  report_sink sink_u (.clk(clk), .rst_n(rst_n), .report_correctable(rc),
    .report_nonfatal(rn), .report_fatal(rf), .cor_cnt(cor_cnt), .unc_cnt(unc_cnt));

  // Free-running clock, 4 ns period.
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : stop_test

  // Write with address and data offered together; each is released once taken.
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    r = 2'bxx;
    @(posedge clk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.bready <= 1'b1;
    repeat (20)
    begin
      @(posedge clk);
      if (req.awvalid && rsp.awready)
        req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready)
        req.wvalid <= 1'b0;
      if (req.bready && rsp.bvalid)
      begin
        r = rsp.bresp;
        req.bready <= 1'b0;
        break;
      end
    end
    chk(34'(r), 34'(er));
  endtask : wr

  task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [33:0] r;
    r = 'x;
    @(posedge clk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    repeat (20)
    begin
      @(posedge clk);
      if (req.arvalid && rsp.arready)
        req.arvalid <= 1'b0;
      if (req.rready && rsp.rvalid)
      begin
        r = {rsp.rresp, rsp.rdata};
        req.rready <= 1'b0;
        break;
      end
    end
    chk(r, {er, e});
  endtask : rd

  // Bus write that also updates the model; bit 31 fields follow their enables.
  task automatic wrm(input logic [31:0] a, input logic [31:0] d);
    wr(a, d, aer_pkg::RESP_OKAY);
    if (a == aer_pkg::STATUS_OFFSET)
      stat &= ~d;
    if (a == aer_pkg::MASK_OFFSET)
      mask = d & aer_pkg::CORR_BITS & {mem[0], 31'h7FFFFFFF};
    if (a == aer_pkg::SEVERITY_OFFSET)
      sev = d & aer_pkg::SEV_BITS & {mem[1], 31'h7FFFFFFF};
    if (a == aer_pkg::MEMCTL_OFFSET)
    begin
      mem = d & aer_pkg::MEMCTL_BITS;
      stat[31] &= mem[0];
      mask[31] &= mem[0];
      sev[31] &= mem[1];
    end
  endtask : wrm

  task automatic chk_all();
    rd(aer_pkg::STATUS_OFFSET, stat, aer_pkg::RESP_OKAY);
    rd(aer_pkg::MASK_OFFSET, mask, aer_pkg::RESP_OKAY);
    rd(aer_pkg::SEVERITY_OFFSET, sev, aer_pkg::RESP_OKAY);
    rd(aer_pkg::MEMCTL_OFFSET, mem, aer_pkg::RESP_OKAY);
  endtask : chk_all

  // One-cycle event burst; reports are judged the cycle after the detectors fire.
  task automatic ev(input logic [6:0] c, input logic [3:0] u, input logic [3:0] m);
    logic [31:0] hit;
    logic [3:0] live;
    logic [3:0] sb;
    hit = 32'h0;
    for (int i = 0; i < aer_pkg::CORR_COUNT; i++)
      hit[aer_pkg::CORR_POS[i]] = c[i];
    hit[aer_pkg::SINGLE_BIT_POS] = hit[aer_pkg::SINGLE_BIT_POS] & mem[0];
    live = u & ~m & {mem[1], 3'h7};
    sb = {sev[31], sev[21:19]};
    @(posedge clk);
    ce <= c;
    ue <= u;
    um <= m;
    @(posedge clk);
    ce <= '0;
    ue <= '0;
    @(posedge clk);
    chk(34'(rc), 34'(|(hit & ~mask)));
    chk(34'(rf), 34'(|(live & sb)));
    chk(34'(rn), 34'(|(live & ~sb)));
    stat |= hit;
    exp_cor += int'(|(hit & ~mask));
    exp_unc += int'(|live);
  endtask : ev

  // Main sequence.
  initial
  begin
    seed = 32'h00003024;
    rst_n = 1'b0;
    hot_rst_n = 1'b1;
    req = '0;
    ce = '0;
    ue = '0;
    um = '0;
    err_total = 0;
    num_checks = 0;
    exp_cor = 0;
    exp_unc = 0;
    stat = aer_pkg::STATUS_RESET;
    mask = aer_pkg::MASK_RESET;
    sev = 32'h0;
    mem = 32'h0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    chk_all();
    wr(32'h00000118, 32'hFFFFFFFF, aer_pkg::RESP_SLVERR);
    rd(32'h00000118, 32'h0, aer_pkg::RESP_SLVERR);
    $display("reset and map test done");
    for (int k = 0; k < 4; k++)
    begin
      wrm(aer_pkg::MEMCTL_OFFSET, 32'(k));
      wrm(aer_pkg::MASK_OFFSET, 32'hFFFFFFFF);
      wrm(aer_pkg::SEVERITY_OFFSET, 32'hFFFFFFFF);
      chk_all();
    end
    $display("enable test done");
    repeat (60)
    begin
      wrm(aer_pkg::MEMCTL_OFFSET, rnd());
      wrm(aer_pkg::MASK_OFFSET, rnd());
      wrm(aer_pkg::SEVERITY_OFFSET, rnd());
      repeat (3)
      begin
        x = rnd() & rnd();
        ev(x[6:0], x[10:7], x[14:11]);
      end
      chk_all();
      wrm(aer_pkg::STATUS_OFFSET, rnd());
    end
    chk(34'(cor_cnt), 34'(exp_cor));
    chk(34'(unc_cnt), 34'(exp_unc));
    $display("event test done");
    @(posedge clk);
    hot_rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    hot_rst_n <= 1'b1;
    chk_all();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    stat = aer_pkg::STATUS_RESET;
    mask = aer_pkg::MASK_RESET;
    sev = 32'h0;
    mem = 32'h0;
    chk_all();
    $display("reset test done");
    stop_test();
  end

  // Cuts a hang short well past the expected run length.
  initial
  begin
    #200000;
    err_total++;
    stop_test();
  end
endmodule : aer_corr_regs_tb
`default_nettype wire
